// file: mon_pkg.sv
// Constants, types and register map of the bus throughput and latency monitor.
// Assumes a single 125 MHz core clock; every observed input is synchronous to it.
//
// Overview of operation
// - Only the memory slave read and write channels and the two video taps are watched, nothing else.
// - The monitor only listens; it never drives, stalls or creates bus signals.
// - Up to four observed slots exist (NUM_SLOTS); software picks which one feeds the counters.
// - Latency counts pixel clock cycles from source frame out to display out.
// - Latency starts on source active data, ends on compositor, framed by syncs.
// - Count read bytes, write bytes, read requests, write requests, write responses.
// - Software start and stop writes open and close the counting window.
// - A global counter counts core clock cycles between start and stop.
// - Counter width is selectable by software as 32 or 64 bits.
// - Every metric's final value is readable through the register port.
// - Counters other than the cycle counter advance only on qualified valid, ready and strobe handshakes.
// - All control and result registers are reachable through the register slave.
package mon_pkg;

  localparam int STRB_W = 32;
  localparam int VID_W = 24;
  localparam int CNT_W = 64;
  localparam int AMT_W = 8;
  localparam int LAT_W = 32;
  localparam int NUM_CNT = 6;

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_SLOT = 8'h08;
  localparam logic [7:0] ADR_LAT = 8'h0C;
  localparam logic [7:0] ADR_CNT_LO = 8'h10;
  localparam logic [7:0] ADR_CNT_HI = 8'h40;

  // Control and status field positions
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_WIDE = 2;
  localparam int CTRL_ARM = 3;
  localparam int ST_CNT_LSB = 0;
  localparam int ST_LAT_LSB = 4;

  // Values after reset
  localparam logic WIDE_RST = 1'b1;
  localparam logic [1:0] SLOT_RST = 2'h0;

  // Counter indices
  localparam int CI_RDBYTES = 0;
  localparam int CI_WRBYTES = 1;
  localparam int CI_RDREQ = 2;
  localparam int CI_WRREQ = 3;
  localparam int CI_WRRESP = 4;
  localparam int CI_CYCLES = 5;

  typedef enum logic [1:0] {
    CNT_IDLE = 2'b00,
    CNT_RUN = 2'b01,
    CNT_HOLD = 2'b10
  } cnt_state_t;

  typedef enum logic [2:0] {
    LAT_IDLE = 3'b000,
    LAT_WAIT_SYNC = 3'b001,
    LAT_WAIT_SRC = 3'b010,
    LAT_COUNT = 3'b011,
    LAT_DONE = 3'b100
  } lat_state_t;

  typedef struct packed {
    logic arvalid;
    logic arready;
    logic rvalid;
    logic rready;
    logic awvalid;
    logic awready;
    logic wvalid;
    logic wready;
    logic [STRB_W-1:0] wstrb;
    logic bvalid;
    logic bready;
  } axi_obs_t;

  typedef struct packed {
    logic frameSync;
    logic active;
    logic [VID_W-1:0] data;
  } vid_tap_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } wb_req_t;

endpackage

// file: event_counter.sv
// One metric counter with synchronous clear and 32/64-bit mode.
// Assumes the caller gates the amount to zero outside the counting window.
`timescale 1ns/100ps
module event_counter #(
  parameter int W = 64,
  parameter int AW = 8
) (
  input logic clk,
  input logic rst_n,
  input logic clear,
  input logic [AW-1:0] amount,
  input logic wide,
  output logic [W-1:0] count
);

  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;

  ////////////////////////////////////////////////////////////
  // Narrow mode needs bits above bit 31 to clear, so W must exceed 32
  if (W <= 32 || AW > 32) begin : g_chk
    $error("event_counter: unsupported width");
  end

  ////////////////////////////////////////////////////////////
  // Next value; narrow mode wraps at 32 bits by forcing the top to zero
  always_comb begin
    count_nxt = count_r + W'(amount);
    if (clear) begin
      count_nxt = '0;
    end
    if (!wide) begin
      count_nxt[W-1:32] = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

endmodule

// file: bus_monitor.sv
// Top of the bus throughput and frame latency monitor with its register slave.
// Assumes all inputs synchronous to clk, and clk more than twice the pixel clock.
`timescale 1ns/100ps
module bus_monitor #(
  parameter int NUM_SLOTS = 4,
  parameter int BEAT_BYTES = mon_pkg::STRB_W
) (
  input logic clk,
  input logic rst_n,
  input mon_pkg::wb_req_t wbReq,
  output logic wbAck,
  output logic [31:0] wbDatO,
  input mon_pkg::axi_obs_t slots [NUM_SLOTS],
  input logic vidClk,
  input mon_pkg::vid_tap_t srcTap,
  input mon_pkg::vid_tap_t dispTap
);

  ////////////////////////////////////////////////////////////
  // Elaboration checks
  if (NUM_SLOTS < 1 || NUM_SLOTS > 4) begin : g_chk_slots
    $error("bus_monitor: NUM_SLOTS must be 1 to 4");
  end
  if (BEAT_BYTES < 1 || BEAT_BYTES > 128) begin : g_chk_beat
    $error("bus_monitor: BEAT_BYTES must be 1 to 128");
  end

  ////////////////////////////////////////////////////////////
  // Declarations
  logic ack_r, ack_nxt;
  logic [31:0] dat_r, dat_nxt;
  logic wide_r, wide_nxt;
  logic [1:0] slot_r, slot_nxt;
  mon_pkg::cnt_state_t cnt_r, cnt_nxt;
  mon_pkg::lat_state_t lat_r, lat_nxt;
  logic [mon_pkg::LAT_W-1:0] latCnt_r, latCnt_nxt;
  logic [mon_pkg::VID_W-1:0] first_r, first_nxt;
  logic dispSeen_r, dispSeen_nxt;
  logic srcSyncD_r, dispSyncD_r, vidClkD_r;
  logic wrEn, wrCtrl, startPulse, stopPulse, armPulse;
  logic pixEdge, srcSyncRise, dispSyncRise;
  logic [31:0] rdData;
  logic [2:0] cntIdx;
  mon_pkg::axi_obs_t obs;
  logic [mon_pkg::AMT_W-1:0] amt [mon_pkg::NUM_CNT];
  logic [mon_pkg::CNT_W-1:0] cntVal [mon_pkg::NUM_CNT];
  logic [mon_pkg::AMT_W-1:0] strbBytes;
  logic running;

  ////////////////////////////////////////////////////////////
  // Register slave: ack one cycle after the request, dropped the next cycle.
  // Writes act on the edge where the master sees ack, so a request held
  // until ack writes only once.
  assign wrEn = wbReq.cyc & wbReq.stb & wbReq.we & ack_r;
  assign wrCtrl = wrEn & wbReq.sel[0] & (wbReq.adr == mon_pkg::ADR_CTRL);
  assign startPulse = wrCtrl & wbReq.dat[mon_pkg::CTRL_START];
  assign stopPulse = wrCtrl & wbReq.dat[mon_pkg::CTRL_STOP];
  assign armPulse = wrCtrl & wbReq.dat[mon_pkg::CTRL_ARM];
  assign cntIdx = 3'(wbReq.adr[5:3] - 3'h2);

  // Read mux; unmapped offsets read zero but are still acknowledged
  always_comb begin
    rdData = 32'h0;
    if (wbReq.adr == mon_pkg::ADR_CTRL) begin
      rdData[mon_pkg::CTRL_WIDE] = wide_r;
    end else if (wbReq.adr == mon_pkg::ADR_STATUS) begin
      rdData[mon_pkg::ST_CNT_LSB +: 2] = cnt_r;
      rdData[mon_pkg::ST_LAT_LSB +: 3] = lat_r;
    end else if (wbReq.adr == mon_pkg::ADR_SLOT) begin
      rdData[1:0] = slot_r;
    end else if (wbReq.adr == mon_pkg::ADR_LAT) begin
      rdData = latCnt_r;
    end else if (wbReq.adr >= mon_pkg::ADR_CNT_LO && wbReq.adr < mon_pkg::ADR_CNT_HI
                 && wbReq.adr[1:0] == 2'h0) begin
      rdData = wbReq.adr[2] ? cntVal[cntIdx][63:32] : cntVal[cntIdx][31:0];
    end
  end

  // Bus and configuration next values
  always_comb begin
    ack_nxt = wbReq.cyc & wbReq.stb & ~ack_r;
    dat_nxt = ack_nxt ? rdData : dat_r;
    wide_nxt = wide_r;
    slot_nxt = slot_r;
    if (wrCtrl) begin
      wide_nxt = wbReq.dat[mon_pkg::CTRL_WIDE];
    end
    if (wrEn && wbReq.sel[0] && wbReq.adr == mon_pkg::ADR_SLOT) begin
      slot_nxt = wbReq.dat[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0;
      wide_r <= mon_pkg::WIDE_RST;
      slot_r <= mon_pkg::SLOT_RST;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
      wide_r <= wide_nxt;
      slot_r <= slot_nxt;
    end
  end

  assign wbAck = ack_r;
  assign wbDatO = dat_r;

  ////////////////////////////////////////////////////////////
  // Observation: inputs only, no path back to the bus at all.
  // Out-of-range selections fall back to slot 0.
  always_comb begin
    obs = slots[0];
    for (int i = 0; i < NUM_SLOTS; i++) begin
      if (slot_r == 2'(i)) begin
        obs = slots[i];
      end
    end
  end

  // Write bytes are counted from the strobes, not the bus width
  always_comb begin
    strbBytes = '0;
    for (int i = 0; i < mon_pkg::STRB_W; i++) begin
      strbBytes = strbBytes + mon_pkg::AMT_W'(obs.wstrb[i]);
    end
  end

  ////////////////////////////////////////////////////////////
  // Counting window: start clears and runs, stop freezes.
  // Start wins when both bits are written together.
  always_comb begin
    cnt_nxt = cnt_r;
    case (cnt_r)
      mon_pkg::CNT_IDLE: begin
        if (startPulse) begin
          cnt_nxt = mon_pkg::CNT_RUN;
        end
      end
      mon_pkg::CNT_RUN: begin
        if (startPulse) begin
          cnt_nxt = mon_pkg::CNT_RUN;
        end else if (stopPulse) begin
          cnt_nxt = mon_pkg::CNT_HOLD;
        end
      end
      mon_pkg::CNT_HOLD: begin
        if (startPulse) begin
          cnt_nxt = mon_pkg::CNT_RUN;
        end
      end
      default: begin
        cnt_nxt = mon_pkg::CNT_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= mon_pkg::CNT_IDLE;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign running = (cnt_r == mon_pkg::CNT_RUN) && !startPulse;

  // Bus metric increments qualified by full handshakes, the cycle count by none; zero outside the window
  always_comb begin
    for (int i = 0; i < mon_pkg::NUM_CNT; i++) begin
      amt[i] = '0;
    end
    if (running) begin
      if (obs.rvalid && obs.rready) begin
        amt[mon_pkg::CI_RDBYTES] = mon_pkg::AMT_W'(BEAT_BYTES);
      end
      if (obs.wvalid && obs.wready) begin
        amt[mon_pkg::CI_WRBYTES] = strbBytes;
      end
      amt[mon_pkg::CI_RDREQ] = mon_pkg::AMT_W'(obs.arvalid & obs.arready);
      amt[mon_pkg::CI_WRREQ] = mon_pkg::AMT_W'(obs.awvalid & obs.awready);
      amt[mon_pkg::CI_WRRESP] = mon_pkg::AMT_W'(obs.bvalid & obs.bready);
      amt[mon_pkg::CI_CYCLES] = mon_pkg::AMT_W'(1);
    end
  end

  // One counter per metric; all cleared together by start
  for (genvar g = 0; g < mon_pkg::NUM_CNT; g++) begin : g_cnt
    event_counter #(
      .W(mon_pkg::CNT_W),
      .AW(mon_pkg::AMT_W)
    ) u_cnt (
      .clk(clk),
      .rst_n(rst_n),
      .clear(startPulse),
      .amount(amt[g]),
      .wide(wide_r),
      .count(cntVal[g])
    );
  end

  ////////////////////////////////////////////////////////////
  // Frame latency. The pixel clock is sampled as a level, so only its
  // rising edges are counted; clk must run above twice its rate.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vidClkD_r <= 1'b0;
      srcSyncD_r <= 1'b0;
      dispSyncD_r <= 1'b0;
    end else begin
      vidClkD_r <= vidClk;
      srcSyncD_r <= srcTap.frameSync;
      dispSyncD_r <= dispTap.frameSync;
    end
  end

  assign pixEdge = vidClk & ~vidClkD_r;
  assign srcSyncRise = srcTap.frameSync & ~srcSyncD_r;
  assign dispSyncRise = dispTap.frameSync & ~dispSyncD_r;

  // Arm, wait for a source frame sync, catch the first active pixel, then
  // count until that pixel value leaves the compositor after its own sync.
  always_comb begin
    lat_nxt = lat_r;
    latCnt_nxt = latCnt_r;
    first_nxt = first_r;
    dispSeen_nxt = dispSeen_r;
    case (lat_r)
      mon_pkg::LAT_IDLE: begin
        if (armPulse) begin
          lat_nxt = mon_pkg::LAT_WAIT_SYNC;
        end
      end
      mon_pkg::LAT_WAIT_SYNC: begin
        if (srcSyncRise) begin
          lat_nxt = mon_pkg::LAT_WAIT_SRC;
        end
      end
      mon_pkg::LAT_WAIT_SRC: begin
        if (pixEdge && srcTap.active) begin
          lat_nxt = mon_pkg::LAT_COUNT;
          first_nxt = srcTap.data;
          latCnt_nxt = '0;
          dispSeen_nxt = 1'b0;
        end
      end
      mon_pkg::LAT_COUNT: begin
        if (dispSyncRise) begin
          dispSeen_nxt = 1'b1;
        end
        if (pixEdge) begin
          if (dispSeen_r && dispTap.active && dispTap.data == first_r) begin
            lat_nxt = mon_pkg::LAT_DONE;
          end else begin
            latCnt_nxt = latCnt_r + 1'b1;
          end
        end
      end
      mon_pkg::LAT_DONE: begin
        if (armPulse) begin
          lat_nxt = mon_pkg::LAT_WAIT_SYNC;
        end
      end
      default: begin
        lat_nxt = mon_pkg::LAT_IDLE;
      end
    endcase
    if (armPulse) begin
      latCnt_nxt = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_r <= mon_pkg::LAT_IDLE;
      latCnt_r <= '0;
      first_r <= '0;
      dispSeen_r <= 1'b0;
    end else begin
      lat_r <= lat_nxt;
      latCnt_r <= latCnt_nxt;
      first_r <= first_nxt;
      dispSeen_r <= dispSeen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_ack_single: assert property (ack_r |=> !ack_r)
    else $error("ack held longer than one cycle");

  a_ack_answers: assert property (wbReq.cyc && wbReq.stb && !ack_r |=> ack_r)
    else $error("request not acknowledged next cycle");

  a_start_clears: assert property (startPulse |=>
      cntVal[mon_pkg::CI_CYCLES] == '0 && cnt_r == mon_pkg::CNT_RUN)
    else $error("start did not clear and run");

  a_cycle_count: assert property (running && wide_r |=>
      cntVal[mon_pkg::CI_CYCLES] == $past(cntVal[mon_pkg::CI_CYCLES]) + 64'h1)
    else $error("cycle counter did not advance");

  a_hold_frozen: assert property (cnt_r == mon_pkg::CNT_HOLD && !startPulse |=>
      $stable(cntVal[mon_pkg::CI_RDBYTES]) && $stable(cntVal[mon_pkg::CI_WRREQ]))
    else $error("counter moved after stop");

  a_stop_holds: assert property (cnt_r == mon_pkg::CNT_RUN && stopPulse && !startPulse
      |=> cnt_r == mon_pkg::CNT_HOLD ##1 $stable(cntVal[mon_pkg::CI_CYCLES]))
    else $error("stop did not freeze the window");

  a_narrow_top: assert property (!wide_r && !$past(wide_r) |->
      cntVal[mon_pkg::CI_CYCLES][63:32] == 32'h0)
    else $error("narrow counter exceeded 32 bits");

  a_wreq_count: assert property (running && wide_r && obs.awvalid && obs.awready |=>
      cntVal[mon_pkg::CI_WRREQ] == $past(cntVal[mon_pkg::CI_WRREQ]) + 64'h1)
    else $error("write request not counted");

  a_wreq_idle: assert property (running && !(obs.awvalid && obs.awready) |=>
      $stable(cntVal[mon_pkg::CI_WRREQ]))
    else $error("write request counted without handshake");

  a_lat_counts: assert property (lat_r == mon_pkg::LAT_COUNT && pixEdge && !armPulse
      && !(dispSeen_r && dispTap.active && dispTap.data == first_r)
      |=> latCnt_r == $past(latCnt_r) + 32'h1)
    else $error("latency missed a pixel edge");

  a_lat_done_hold: assert property (lat_r == mon_pkg::LAT_DONE && !armPulse |=>
      $stable(latCnt_r) && lat_r == mon_pkg::LAT_DONE)
    else $error("latency result changed while done");

  c_window: cover property (startPulse ##[1:400] stopPulse);
  c_lat_done: cover property (lat_r == mon_pkg::LAT_COUNT ##1 lat_r == mon_pkg::LAT_DONE);
  c_read_ack: cover property (wbReq.cyc && wbReq.stb && !wbReq.we ##1 ack_r);
  c_narrow_run: cover property (running && !wide_r);

endmodule

// file: obs_channel_model.sv
// Partner model: one observed memory slave port making random handshakes.
// Assumes the core clock and reset of the bench; it drives one slot and nothing else.
`timescale 1ns/100ps
module obs_channel_model #(
  parameter int SEED_OFS = 0
) (
  input wire logic clk,
  input wire logic rst_n,
  output mon_pkg::axi_obs_t obs
);
  integer seed = 32'hA496 + SEED_OFS;
  logic [4:0] vld;
  logic [4:0] rdy;

  ////////////////////////////////////////////////////////////////////////////////
  // Pending valids stay up until accepted, so a stalled beat is never counted twice
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      obs <= '0;
    end else begin
      vld = {obs.arvalid, obs.rvalid, obs.awvalid, obs.wvalid, obs.bvalid};
      rdy = {obs.arready, obs.rready, obs.awready, obs.wready, obs.bready};
      vld = (vld & ~rdy) | 5'($random(seed));
      rdy = 5'($random(seed));
      if (!(obs.wvalid && !obs.wready)) begin
        obs.wstrb <= $random(seed);
      end
      {obs.arvalid, obs.rvalid, obs.awvalid, obs.wvalid, obs.bvalid} <= vld;
      {obs.arready, obs.rready, obs.awready, obs.wready, obs.bready} <= rdy;
    end
  end
endmodule

// file: bus_monitor_tb.sv
// Self-checking bench for the bus monitor: register bus, counting window, latency.
// Assumes four random slot models and a pixel clock made here at an eighth of clk.
`timescale 1ns/100ps
module bus_monitor_tb;
  logic clk;
  logic rst_n;
  logic vidClk;
  mon_pkg::wb_req_t wbReq;
  logic wbAck;
  logic [31:0] wbDatO;
  mon_pkg::axi_obs_t slots [4];
  mon_pkg::vid_tap_t srcTap;
  mon_pkg::vid_tap_t dispTap;
  integer seed = 32'hA496;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [63:0] mCnt [6] = '{default: 64'h0};
  logic [1:0] mSlot = 2'h0;
  logic mWide = 1'b1;
  logic mRun = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // One core clock; it stands for the faster bus clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  for (genvar g = 0; g < 4; g++) begin : gSlot
    obs_channel_model #(.SEED_OFS(g)) obs_channel_model_inst (.clk(clk), .rst_n(rst_n), .obs(slots[g]));
  end

  bus_monitor #(.NUM_SLOTS(4), .BEAT_BYTES(32)) bus_monitor_inst (
    .clk(clk), .rst_n(rst_n), .wbReq(wbReq), .wbAck(wbAck), .wbDatO(wbDatO),
    .slots(slots), .vidClk(vidClk), .srcTap(srcTap), .dispTap(dispTap)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Reference counters; a register write lands at the edge where ack is seen
  always @(posedge clk) begin
    mon_pkg::axi_obs_t o;
    logic ctl;
    o = slots[mSlot];
    ctl = wbAck && wbReq.cyc && wbReq.we && wbReq.adr == mon_pkg::ADR_CTRL;
    if (wbAck && wbReq.cyc && wbReq.we && wbReq.adr == mon_pkg::ADR_SLOT) begin
      mSlot = wbReq.dat[1:0];
    end
    if (ctl) begin
      mWide = wbReq.dat[mon_pkg::CTRL_WIDE];
    end
    if (ctl && wbReq.dat[mon_pkg::CTRL_START]) begin
      for (int i = 0; i < 6; i++) begin
        mCnt[i] = 64'h0;
      end
      mRun = 1'b1;
    end else if (mRun) begin
      mCnt[0] += (o.rvalid && o.rready) ? 64'd32 : 64'd0;
      mCnt[1] += (o.wvalid && o.wready) ? 64'($countones(o.wstrb)) : 64'd0;
      mCnt[2] += 64'(o.arvalid && o.arready);
      mCnt[3] += 64'(o.awvalid && o.awready);
      mCnt[4] += 64'(o.bvalid && o.bready);
      mCnt[5] += 64'd1;
      if (ctl && wbReq.dat[mon_pkg::CTRL_STOP]) begin
        mRun = 1'b0;
      end
    end
  end

  // Hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Classic single cycle; holds the request until ack, then idles one cycle
  task automatic wb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
    @(posedge clk);
    while (wbAck !== 1'b1) begin
      @(posedge clk);
    end
    q = wbDatO;
    wbReq <= '0;
    @(posedge clk);
  endtask

  task automatic wb_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_xfer(a, 1'b1, d, q);
  endtask

  task automatic wb_read(input logic [7:0] a, output logic [31:0] q);
    wb_xfer(a, 1'b0, 32'h0, q);
  endtask

  // All six counters, low then high word; 32-bit mode wraps and reads 0 high
  task automatic check_counters();
    logic [31:0] q;
    logic [63:0] e;
    for (int i = 0; i < 6; i++) begin
      e = mWide ? mCnt[i] : {32'h0, mCnt[i][31:0]};
      wb_read(mon_pkg::ADR_CNT_LO + 8'(8 * i), q);
      check("counter low", e[31:0], q);
      wb_read(mon_pkg::ADR_CNT_LO + 8'(8 * i + 4), q);
      check("counter high", e[63:32], q);
    end
  endtask

  // One pixel period; taps change while the pixel clock is low
  task automatic pix(input logic sS, input logic sA, input logic dS, input logic dA, input logic [23:0] dD);
    srcTap <= '{frameSync: sS, active: sA, data: 24'h5A5A5A};
    dispTap <= '{frameSync: dS, active: dA, data: dD};
    vidClk <= 1'b0;
    repeat (4) @(posedge clk);
    vidClk <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    logic [31:0] q;
    wbReq = '0;
    vidClk = 1'b0;
    srcTap = '0;
    dispTap = '0;
    rst_n = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    wb_write(mon_pkg::ADR_STATUS, 32'hFFFFFFFF);
    wb_read(mon_pkg::ADR_STATUS, q);
    check("status", 64'h0, q);
    wb_read(mon_pkg::ADR_SLOT, q);
    check("slot", 64'(mon_pkg::SLOT_RST), q);
    check_counters();
    wb_read(8'hF0, q);
    check("unmapped", 64'h0, q);
    // Window on slot 2 while all four slots carry traffic
    wb_write(mon_pkg::ADR_SLOT, 32'h2);
    wb_read(mon_pkg::ADR_SLOT, q);
    check("slot", 64'h2, q);
    wb_write(mon_pkg::ADR_CTRL, 32'h5);
    wb_read(mon_pkg::ADR_STATUS, q);
    check("status", 64'h1, q);
    repeat (300) @(posedge clk);
    wb_write(mon_pkg::ADR_CTRL, 32'h6);
    wb_read(mon_pkg::ADR_STATUS, q);
    check("status", 64'h2, q);
    check_counters();
    repeat (40) @(posedge clk);
    check_counters();
    // Narrow counters on slot 0 with a random window length
    wb_write(mon_pkg::ADR_SLOT, 32'h0);
    wb_write(mon_pkg::ADR_CTRL, 32'h1);
    repeat (100 + ($random(seed) & 63)) @(posedge clk);
    wb_write(mon_pkg::ADR_CTRL, 32'h2);
    check_counters();
    // Start and stop in one write: start wins, so the window opens afresh
    wb_write(mon_pkg::ADR_CTRL, 32'h7);
    wb_read(mon_pkg::ADR_STATUS, q);
    check("status", 64'h1, q);
    wb_write(mon_pkg::ADR_CTRL, 32'h6);
    check_counters();
    // Latency: capture, two sync-framed periods, a wrong pixel, then the match
    wb_write(mon_pkg::ADR_CTRL, 32'hC);
    pix(0, 0, 0, 0, 24'h0);
    pix(1, 0, 0, 0, 24'h0);
    pix(0, 1, 0, 0, 24'h0);
    pix(0, 0, 0, 0, 24'h0);
    pix(0, 0, 1, 0, 24'h0);
    pix(0, 0, 0, 1, 24'hA5A5A5);
    pix(0, 0, 0, 0, 24'h0);
    pix(0, 0, 0, 1, 24'h5A5A5A);
    pix(0, 0, 0, 0, 24'h0);
    wb_read(mon_pkg::ADR_LAT, q);
    check("latency", 64'h4, q);
    wb_read(mon_pkg::ADR_STATUS, q);
    check("latency state", 64'h4, q[6:4]);
    give_verdict();
  end
endmodule
